// ===== hdl/mpid_pkg.sv
// Package: constants and types for the multiprocessor interrupt delivery core
package mpid_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCPU = 4;
  localparam int NSRC = 8;
  localparam int NIO  = 6;  // Sources 0..5 are I/O, the rest directed-only events
  localparam int CPUW = 2;
  localparam int SRCW = 3;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADR_CTP  = 16'h0080;
  localparam logic [15:0] ADR_WHO  = 16'h0090;
  localparam logic [15:0] ADR_ACK  = 16'h00a0;
  localparam logic [15:0] ADR_EOI  = 16'h00b0;
  localparam logic [15:0] ADR_GCR  = 16'h1020;
  localparam logic [15:0] ADR_INIT = 16'h1090;
  localparam logic [15:0] ADR_SPUR = 16'h10e0;
  localparam logic [8:0]  SRC_BLK  = 9'h040;  // Source configs at 0x2000 + 0x10 * index
  localparam int          GCR_PDIS = 29;

  // ----------------------------------------------------------------
  // Reset values and responses
  // ----------------------------------------------------------------
  localparam logic [3:0]  CTP_RST   = 4'hf;
  localparam logic [7:0]  SPUR_RST  = 8'hff;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;

  typedef logic [3:0] mpid_prio_t;

  typedef struct packed {
    logic             mask;
    logic             level;
    logic [NCPU-1:0]  dest;
    mpid_prio_t       prio;
    logic [7:0]       vec;
  } mpid_src_cfg_t;

  localparam mpid_src_cfg_t SRC_RST = '{mask: 1'b1, level: 1'b0, dest: 4'h1,
                                        prio: 4'h0, vec: 8'h00};
endpackage : mpid_pkg

// ===== hdl/mpid_sync.sv
// Three-stage pin synchroniser, output moves once stages two and three agree
`timescale 1ns/1ps
module mpid_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++)
        if (s2_r[i] == s3_r[i])
          dout[i] <= s3_r[i];
    end
  end
endmodule : mpid_sync

// ===== hdl/mpid_pick.sv
// Picks the highest priority request, ties to the lowest index
`timescale 1ns/1ps
module mpid_pick
  import mpid_pkg::*;
(
  input  wire logic                   [NSRC-1:0] req,
  input  wire mpid_prio_t             [NSRC-1:0] prios,
  output logic                                   found,
  output logic                        [SRCW-1:0] idx,
  output mpid_prio_t                             top
);
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    top   = '0;
    // Scan downward so an equal priority at a lower index replaces the earlier pick
    for (int s = NSRC - 1; s >= 0; s--)
      if (req[s] && (!found || prios[s] >= top))
      begin
        found = 1'b1;
        idx   = SRCW'(s);
        top   = prios[s];
      end
  end
endmodule : mpid_pick

// ===== hdl/mpid_core.sv
// Top: interrupt delivery, priority and in-service core with AXI4-Lite registers
// Behaviour
// - Directed events go to every destination bit
// - Interprocessor and timer events are directed, multicast
// - Single-destination I/O is directed, never multicast
// - Multi-destination I/O rotates fairly among destinations
// - Distributed event pending or active on one processor
// - Distributed source locked to processor until its END_OF_INTERRUPT
// - Edges arriving while busy are dropped
// - Each source holds priority 0 to 15
// - Delivery happens at the acknowledge read
// - Deliver only if priority exceeds task priority
// - Private task priority masks equal or lower
// - In-service priority blocks equal or lower sources
// - In service from acknowledge until END_OF_INTERRUPT
// - END_OF_INTERRUPT clears highest in-service interrupt only
// - END_OF_INTERRUPT affects only the writing processor
// - Invalid request at acknowledge returns spurious vector
// - Eligible pending interrupt beats spurious vector
// - Shared register drives processor init lines
// - Identity read returns reader's connection number
// - Reset enters legacy pass-through to processor zero
// - Pass-through off: core routes all events
// - Per-processor registers share one address
// - Task priority resets to 15
// - END_OF_INTERRUPT is a write of zero
`timescale 1ns/1ps
module mpid_core
  import mpid_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [15:0]      awaddr,
  input  wire logic [2:0]       awprot,
  input  wire logic [CPUW-1:0]  awcpu,
  input  wire logic             wvalid,
  output logic                  wready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  output logic                  bvalid,
  input  wire logic             bready,
  output logic      [1:0]       bresp,
  input  wire logic             arvalid,
  output logic                  arready,
  input  wire logic [15:0]      araddr,
  input  wire logic [2:0]       arprot,
  input  wire logic [CPUW-1:0]  arcpu,
  output logic                  rvalid,
  input  wire logic             rready,
  output logic      [31:0]      rdata,
  output logic      [1:0]       rresp,
  input  wire logic [NSRC-1:0]  src_in,
  input  wire logic             legacy_irq,
  output logic      [NCPU-1:0]  cpu_irq,
  output logic      [NCPU-1:0]  cpu_init
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mpid_src_cfg_t           cfg_r    [NSRC];
  logic       [NSRC-1:0]   pend_r   [NCPU];
  logic       [NSRC-1:0]   isv_r    [NCPU];
  mpid_prio_t              ctp_r    [NCPU];
  logic       [31:0]       eoi_r    [NCPU];
  logic       [NSRC-1:0]   own_v_r;
  logic       [CPUW-1:0]   own_c_r  [NSRC];
  logic                    pass_dis_r;
  logic       [7:0]        spur_r;
  logic       [NSRC-1:0]   prev_r;
  logic       [15:0]       aw_addr_r;
  logic       [CPUW-1:0]   aw_cpu_r;
  logic       [31:0]       w_data_r;
  logic       [3:0]        w_strb_r;

  logic       [NSRC:0]     pin_s;
  logic       [NSRC-1:0]   src_s;
  logic                    legacy_s;
  mpid_prio_t [NSRC-1:0]   prios;
  logic       [NSRC-1:0]   elig     [NCPU];
  logic       [NSRC-1:0]   set_pend [NCPU];
  logic       [NSRC-1:0]   ack_set  [NCPU];
  logic       [NSRC-1:0]   eoi_clr  [NCPU];
  logic       [NCPU-1:0]   best_v;
  logic       [SRCW-1:0]   best_i   [NCPU];
  logic       [NCPU-1:0]   isv_v;
  logic       [SRCW-1:0]   isv_i    [NCPU];
  mpid_prio_t              isp      [NCPU];
  logic       [NCPU-1:0]   ack_hit;
  logic       [NCPU-1:0]   eoi_hit;
  logic       [NSRC-1:0]   own_set;
  logic       [CPUW-1:0]   own_tgt  [NSRC];
  logic       [NSRC-1:0]   own_clr;
  logic                    wr_do;
  logic                    rd_do;
  logic       [31:0]       wmerge;

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (st[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction : merge

  function automatic logic [CPUW-1:0] next_cpu(logic [NCPU-1:0] d, logic [CPUW-1:0] last);
    logic [CPUW-1:0] r;
    logic [CPUW-1:0] t;
    r = last;
    for (int k = NCPU; k >= 1; k--)
    begin
      t = last + CPUW'(k);
      if (d[t])
        r = t;
    end
    return r;
  endfunction : next_cpu

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  mpid_sync #(.W(NSRC + 1)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({legacy_irq, src_in}),
    .dout    (pin_s)
  );
  assign src_s    = pin_s[NSRC-1:0];
  assign legacy_s = pin_s[NSRC];

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  assign wr_do  = !awready && !wready && !bvalid;
  assign rd_do  = arvalid && arready;
  assign wmerge = merge(32'h0, w_data_r, w_strb_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      aw_addr_r <= '0;
      aw_cpu_r  <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready   <= 1'b0;
        aw_addr_r <= awaddr;
        aw_cpu_r  <= awcpu;
      end
      if (wvalid && wready)
      begin
        wready   <= 1'b0;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_do)
      begin
        bvalid <= 1'b1;
        bresp  <= RESP_OKAY;
        if (!(aw_addr_r inside {ADR_CTP, ADR_WHO, ADR_ACK, ADR_EOI, ADR_GCR, ADR_INIT,
                                ADR_SPUR}) &&
            !(aw_addr_r[15:7] == SRC_BLK && aw_addr_r[3:0] == 4'h0))
          bresp <= RESP_SLV;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pass_dis_r <= 1'b0;
      spur_r     <= SPUR_RST;
      cpu_init   <= '0;
      for (int c = 0; c < NCPU; c++)
      begin
        ctp_r[c] <= CTP_RST;
        eoi_r[c] <= '0;
      end
      for (int s = 0; s < NSRC; s++)
        cfg_r[s] <= SRC_RST;
    end
    else if (wr_do)
    begin
      case (aw_addr_r)
        ADR_CTP:  ctp_r[aw_cpu_r] <= merge({28'h0, ctp_r[aw_cpu_r]}, w_data_r, w_strb_r)
                                     [3:0];
        ADR_EOI:  eoi_r[aw_cpu_r] <= merge(eoi_r[aw_cpu_r], w_data_r, w_strb_r);
        ADR_GCR:  if (w_strb_r[GCR_PDIS/8])
                    pass_dis_r <= w_data_r[GCR_PDIS];
        ADR_INIT: cpu_init <= merge({28'h0, cpu_init}, w_data_r, w_strb_r)[NCPU-1:0];
        ADR_SPUR: spur_r <= merge({24'h0, spur_r}, w_data_r, w_strb_r)[7:0];
        default:
          if (aw_addr_r[15:7] == SRC_BLK && aw_addr_r[3:0] == 4'h0)
            cfg_r[aw_addr_r[6:4]] <= merge({14'h0, cfg_r[aw_addr_r[6:4]]}, w_data_r,
                                           w_strb_r)[$bits(mpid_src_cfg_t)-1:0];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-processor selection
  // ----------------------------------------------------------------
  genvar gc;
  genvar gs;
  for (gs = 0; gs < NSRC; gs++)
  begin : g_prio
    assign prios[gs] = cfg_r[gs].prio;
  end

  for (gc = 0; gc < NCPU; gc++)
  begin : g_cpu
    for (gs = 0; gs < NSRC; gs++)
    begin : g_el
      // A level source whose pin went high, a mask or a raised task priority all fall out here
      assign elig[gc][gs] = pend_r[gc][gs] && !cfg_r[gs].mask &&
                            (!cfg_r[gs].level || !src_s[gs]) &&
                            prios[gs] > ctp_r[gc] &&
                            prios[gs] > isp[gc];
    end

    mpid_pick u_best (
      .req   (elig[gc]),
      .prios (prios),
      .found (best_v[gc]),
      .idx   (best_i[gc]),
      .top   ()
    );

    mpid_pick u_isv (
      .req   (isv_r[gc]),
      .prios (prios),
      .found (isv_v[gc]),
      .idx   (isv_i[gc]),
      .top   (isp[gc])
    );

    assign ack_hit[gc] = rd_do && araddr == ADR_ACK && arcpu == CPUW'(gc) && pass_dis_r;
    assign eoi_hit[gc] = wr_do && aw_addr_r == ADR_EOI && aw_cpu_r == CPUW'(gc) &&
                         wmerge == 32'h0;
    assign ack_set[gc] = (ack_hit[gc] && best_v[gc]) ? (NSRC'(1) << best_i[gc]) : '0;
    assign eoi_clr[gc] = (eoi_hit[gc] && isv_v[gc]) ? (NSRC'(1) << isv_i[gc]) : '0;
  end

  // ----------------------------------------------------------------
  // Event dispatch
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int c = 0; c < NCPU; c++)
      set_pend[c] = '0;
    for (int s = 0; s < NSRC; s++)
    begin
      own_set[s] = 1'b0;
      own_tgt[s] = next_cpu(cfg_r[s].dest, own_c_r[s]);
      own_clr[s] = own_v_r[s] && eoi_clr[own_c_r[s]][s];
      // Routing only runs once pass-through is switched off
      if (pass_dis_r && !cfg_r[s].mask &&
          (cfg_r[s].level ? !src_s[s] : (src_s[s] && !prev_r[s])))
      begin
        if (s < NIO && $countones(cfg_r[s].dest) > 1)
        begin
          if (!own_v_r[s])
          begin
            own_set[s]                = 1'b1;
            set_pend[own_tgt[s]][s]   = 1'b1;
          end
        end
        else
          for (int c = 0; c < NCPU; c++)
            if (cfg_r[s].dest[c] && !pend_r[c][s] && !isv_r[c][s])
              set_pend[c][s] = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_r  <= '0;
      own_v_r <= '0;
      for (int s = 0; s < NSRC; s++)
        own_c_r[s] <= '0;
    end
    else
    begin
      prev_r <= src_s;
      for (int s = 0; s < NSRC; s++)
        if (own_set[s])
        begin
          own_v_r[s] <= 1'b1;
          own_c_r[s] <= own_tgt[s];
        end
        else if (own_clr[s])
          own_v_r[s] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pending and in-service state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      for (int c = 0; c < NCPU; c++)
      begin
        pend_r[c] <= '0;
        isv_r[c]  <= '0;
      end
    else
      for (int c = 0; c < NCPU; c++)
      begin
        pend_r[c] <= (pend_r[c] & ~ack_set[c]) | set_pend[c];
        isv_r[c]  <= (isv_r[c] & ~eoi_clr[c]) | ack_set[c];
      end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cpu_irq <= '0;
    else
      for (int c = 0; c < NCPU; c++)
        cpu_irq[c] <= pass_dis_r ? best_v[c] : (c == 0 && legacy_s);
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else
    begin
      if (rd_do)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= RESP_OKAY;
        rdata   <= '0;
        case (araddr)
          ADR_CTP:  rdata <= {28'h0, ctp_r[arcpu]};
          ADR_WHO:  rdata <= {30'h0, arcpu};
          ADR_ACK:  rdata <= {24'h0, best_v[arcpu] && pass_dis_r ?
                                     cfg_r[best_i[arcpu]].vec : spur_r};
          ADR_EOI:  rdata <= eoi_r[arcpu];
          ADR_GCR:  rdata <= {2'h0, pass_dis_r, 29'h0};
          ADR_INIT: rdata <= {28'h0, cpu_init};
          ADR_SPUR: rdata <= {24'h0, spur_r};
          default:
            if (araddr[15:7] == SRC_BLK && araddr[3:0] == 4'h0)
              rdata <= {14'h0, cfg_r[araddr[6:4]]};
            else
              rresp <= RESP_SLV;
        endcase
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [7:0] ack_vec0;
  assign ack_vec0 = cfg_r[best_i[0]].vec;

  property p_ctp_reset;
    @(posedge aclk) $rose(aresetn) |-> ctp_r[0] == CTP_RST && !pass_dis_r;
  endproperty
  a_ctp_reset: assert property (p_ctp_reset) else $error("task priority not 15 after reset");

  property p_above_ctp;
    @(posedge aclk) disable iff (!aresetn)
      ack_hit[0] && best_v[0] |-> prios[best_i[0]] > ctp_r[0] && prios[best_i[0]] != 4'h0;
  endproperty
  a_above_ctp: assert property (p_above_ctp) else $error("delivered at or below task level");

  property p_nested;
    @(posedge aclk) disable iff (!aresetn)
      ack_hit[0] && best_v[0] && isv_v[0] |-> prios[best_i[0]] > isp[0];
  endproperty
  a_nested: assert property (p_nested) else $error("preempted by equal or lower source");

  property p_ack_vec;
    @(posedge aclk) disable iff (!aresetn)
      ack_hit[0] && best_v[0] |=> rvalid && rdata == {24'h0, $past(ack_vec0)} && isv_r[0] != '0;
  endproperty
  a_ack_vec: assert property (p_ack_vec) else $error("acknowledge vector wrong");

  property p_spur;
    @(posedge aclk) disable iff (!aresetn)
      ack_hit[0] && !best_v[0] |=> rdata == {24'h0, $past(spur_r)} && $stable(isv_r[0]);
  endproperty
  a_spur: assert property (p_spur) else $error("spurious vector not returned");

  property p_eoi;
    @(posedge aclk) disable iff (!aresetn)
      eoi_hit[0] && isv_v[0] && !ack_hit[0] |=> $countones(isv_r[0]) ==
        $countones($past(isv_r[0])) - 1;
  endproperty
  a_eoi: assert property (p_eoi) else $error("END_OF_INTERRUPT did not clear one in-service bit");

  property p_who;
    @(posedge aclk) disable iff (!aresetn)
      rd_do && araddr == ADR_WHO |=> rvalid && rdata[CPUW-1:0] == $past(arcpu);
  endproperty
  a_who: assert property (p_who) else $error("identity read wrong");

  property p_pass;
    @(posedge aclk) disable iff (!aresetn)
      !pass_dis_r ##1 !pass_dis_r |-> cpu_irq[NCPU-1:1] == '0 && isv_r[0] == $past(isv_r[0]);
  endproperty
  a_pass: assert property (p_pass) else $error("routing active in pass-through");

  for (gs = 0; gs < NIO; gs++)
  begin : g_once
    logic [NCPU-1:0] busy;
    for (gc = 0; gc < NCPU; gc++)
    begin : g_b
      assign busy[gc] = pend_r[gc][gs] || isv_r[gc][gs];
    end
    property p_once;
      @(posedge aclk) disable iff (!aresetn)
        own_v_r[gs] |-> $onehot0(busy) && (busy == '0 || busy[own_c_r[gs]]);
    endproperty
    a_once: assert property (p_once) else $error("distributed event on two processors");
  end

  c_ack:   cover property (@(posedge aclk) disable iff (!aresetn) ack_hit[0] && best_v[0]);
  c_spur:  cover property (@(posedge aclk) disable iff (!aresetn) ack_hit[0] && !best_v[0]);
  c_eoi:   cover property (@(posedge aclk) disable iff (!aresetn) eoi_hit[0] && isv_v[0]);
  c_dist:  cover property (@(posedge aclk) disable iff (!aresetn) own_set[0]);
endmodule : mpid_core

// ===== verification/mpid_cpu_model.sv
// Processor cores model: AXI4-Lite master with acknowledge and end-of-interrupt
`timescale 1ns/1ps
module mpid_cpu_model
  import mpid_pkg::*;
(
  input  wire logic            aclk,
  output logic                 awvalid,
  input  wire logic            awready,
  output logic      [15:0]     awaddr,
  output logic      [CPUW-1:0] awcpu,
  output logic                 wvalid,
  input  wire logic            wready,
  output logic      [31:0]     wdata,
  input  wire logic            bvalid,
  output logic                 bready,
  input  wire logic [1:0]      bresp,
  output logic                 arvalid,
  input  wire logic            arready,
  output logic      [15:0]     araddr,
  output logic      [CPUW-1:0] arcpu,
  input  wire logic            rvalid,
  output logic                 rready,
  input  wire logic [31:0]     rdata,
  input  wire logic [1:0]      rresp
);
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, awcpu, arcpu, wdata} = '0;
  end

  // Address and data released one by one as each is taken
  task automatic wr(input logic [CPUW-1:0] c, input logic [15:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    awcpu <= c;
    wdata <= d;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [CPUW-1:0] c, input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    arcpu <= c;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // Software never closes a spurious acknowledge
  task automatic isr_end(input logic [CPUW-1:0] c, input logic [31:0] v);
    logic [1:0] r;
    if (v[7:0] !== SPUR_RST) wr(c, ADR_EOI, 32'h0, r);
  endtask : isr_end
endmodule : mpid_cpu_model

// ===== verification/testbench.sv
// Self-checking bench for the interrupt delivery core
`timescale 1ns/1ps
module testbench
  import mpid_pkg::*;
;
  logic            aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready, legacy_irq;
  logic [15:0]     awaddr, araddr;
  logic [CPUW-1:0] awcpu, arcpu;
  logic [31:0]     wdata, rdata, seed, v;
  logic [1:0]      bresp, rresp, r;
  logic [NSRC-1:0] src_in;
  logic [NCPU-1:0] cpu_irq, cpu_init;
  logic [3:0]      p, q;
  int              err_total, cmp_count, o;

  mpid_core mpid_core_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .awcpu(awcpu), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .arcpu(arcpu), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .src_in(src_in), .legacy_irq(legacy_irq), .cpu_irq(cpu_irq), .cpu_init(cpu_init));
  mpid_cpu_model mpid_cpu_model_i (.aclk(aclk), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awcpu(awcpu), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arcpu(arcpu), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [31:0] cfg(input logic [7:0] vec, input logic [3:0] pr,
                                      input logic [3:0] d, input logic m);
    return {14'h0, m, 1'b0, d, pr, vec};
  endfunction : cfg

  function automatic logic [15:0] sa(input int i);
    return 16'h2000 + 16'(i * 16);
  endfunction : sa

  // Delivered only when source priority is strictly above task priority
  function automatic logic [3:0] dlv(input logic [3:0] pr, input logic [3:0] t);
    return (pr > t) ? 4'h4 : 4'h0;
  endfunction : dlv

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic w(input int c, input logic [15:0] a, input logic [31:0] d);
    mpid_cpu_model_i.wr(2'(c), a, d, r);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask : w

  task automatic rc(input int c, input logic [15:0] a, input logic [31:0] e, input string n);
    mpid_cpu_model_i.rd(2'(c), a, v, r);
    chk(n, e, v);
  endtask : rc

  // Held four cycles so the three-stage synchroniser sees the edge
  task automatic pulse(input logic [NSRC-1:0] m);
    src_in <= m;
    repeat (4) @(posedge aclk);
    src_in <= '0;
    repeat (8) @(posedge aclk);
  endtask : pulse

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // ----
  // Clock, watchdog and tests
  // ----
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    $display("ERROR watchdog expected end seen hang");
    end_sim();
  end

  initial
  begin
    {aresetn, legacy_irq, src_in, err_total, cmp_count} = '0;
    seed = 32'h00000bc8;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int c = 0; c < NCPU; c++)
    begin
      rc(c, ADR_CTP, 32'hf, "ctp");
      rc(c, ADR_WHO, 32'(c), "who");
    end
    rc(1, ADR_SPUR, 32'hff, "spur");
    mpid_cpu_model_i.rd(2'h0, 16'h3000, v, r);
    chk("rresp", {30'h0, RESP_SLV}, {30'h0, r});
    legacy_irq <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("pass", 32'h1, {28'h0, cpu_irq});
    rc(0, ADR_ACK, 32'hff, "ack");
    w(0, ADR_GCR, 32'h20000000);
    repeat (8) @(posedge aclk);
    chk("nopass", 32'h0, {28'h0, cpu_irq});
    legacy_irq <= 1'b0;
    w(1, ADR_INIT, 32'h5);
    chk("init", 32'h5, {28'h0, cpu_init});
    w(2, ADR_INIT, 32'h0);
    for (int c = 0; c < NCPU; c++) w(c, ADR_CTP, 32'h0);
    $display("test reset done");
    w(0, sa(6), cfg(8'h66, 4'h5, 4'hf, 1'b0));
    pulse(8'h40);
    chk("mcast", 32'hf, {28'h0, cpu_irq});
    for (int c = 0; c < NCPU; c++)
    begin
      rc(c, ADR_ACK, 32'h66, "ack");
      mpid_cpu_model_i.isr_end(2'(c), v);
    end
    $display("test directed done");
    w(0, sa(0), cfg(8'h10, 4'h4, 4'h3, 1'b0));
    pulse(8'h01);
    o = int'(cpu_irq[1]);
    chk("dist", 32'h1 << o, {28'h0, cpu_irq});
    rc(o, ADR_ACK, 32'h10, "ack");
    pulse(8'h01);
    chk("busy", 32'h0, {28'h0, cpu_irq});
    w(o, ADR_EOI, 32'h0);
    repeat (8) @(posedge aclk);
    chk("drop", 32'h0, {28'h0, cpu_irq});
    pulse(8'h01);
    chk("rr", 32'h1 << (1 - o), {28'h0, cpu_irq});
    rc(1 - o, ADR_ACK, 32'h10, "ack");
    w(1 - o, ADR_EOI, 32'h0);
    $display("test distributed done");
    for (int i = 0; i < 5; i++)
    begin
      v = xs();
      p = (v[3:0] == 4'h0) ? 4'h1 : v[3:0];
      q = (i == 3) ? p : v[7:4];
      if (i == 4) {p, q} = 8'h00;
      w(2, ADR_CTP, {28'h0, q});
      w(0, sa(1), cfg(8'h41, p, 4'h4, 1'b0));
      pulse(8'h02);
      chk("prio", {28'h0, dlv(p, q)}, {28'h0, cpu_irq});
      w(2, ADR_CTP, 32'h0);
      rc(2, ADR_ACK, (p != 4'h0) ? 32'h41 : 32'hff, "ack");
      mpid_cpu_model_i.isr_end(2'h2, v);
    end
    $display("test priority done");
    w(0, sa(2), cfg(8'h23, 4'h3, 4'h8, 1'b0));
    w(0, sa(3), cfg(8'h37, 4'h7, 4'h8, 1'b0));
    pulse(8'h0c);
    rc(3, ADR_ACK, 32'h37, "ack");
    repeat (2) @(posedge aclk);
    chk("nest", 32'h0, {28'h0, cpu_irq});
    w(0, ADR_EOI, 32'h0);
    w(3, ADR_EOI, 32'h5);
    repeat (2) @(posedge aclk);
    chk("eoi", 32'h0, {28'h0, cpu_irq});
    w(3, ADR_EOI, 32'h0);
    repeat (2) @(posedge aclk);
    chk("eoi", 32'h8, {28'h0, cpu_irq});
    pulse(8'h08);
    w(0, sa(2), cfg(8'h23, 4'h3, 4'h8, 1'b1));
    rc(3, ADR_ACK, 32'h37, "ack");
    w(3, ADR_EOI, 32'h0);
    rc(3, ADR_ACK, 32'hff, "spur");
    mpid_cpu_model_i.isr_end(2'h3, v);
    $display("test nesting done");
    // Level source on processor zero, active while its pin is low
    w(0, sa(4), 32'h00011244);
    repeat (8) @(posedge aclk);
    chk("level", 32'h1, {28'h0, cpu_irq});
    src_in <= 8'h10;
    repeat (8) @(posedge aclk);
    rc(0, ADR_ACK, 32'hff, "lvlspur");
    $display("test level done");
    end_sim();
  end
endmodule : testbench
